// *** design/sensor_regs_pkg.sv ***
// Behaviour
// - decode full 14-bit register address
// - error bit 10: core overflow, read-only
// - error bit 9: offset calibration pending
// - error bits 8,7: broken element, oscillator fault
// - error bits 6,5,4: checksum, command, framing
// - error bits 3,2: parity double, single fix
// - error bit 1: gain 255 and field half
// - error bit 0: gain at 0 or 255
// - reading error flags returns then clears them
// - control bit 0 enables OTP access
// - writing control bit 3 starts OTP burn
// - writing control bit 2 reloads shadow registers
// - diagnostic frame counter, bits 12,11
// - diagnostic bits 7..1 core status flags
// - raw sine and cosine at consecutive addresses
// - speed as 14-bit signed value
// - magnitude in bits 13..0, read-only
// - uncompensated angle, read-only
// - compensated angle at top address
// - 7-bit parity sum over configuration
// - select bit swaps top address angle
package sensor_regs_pkg;

    localparam logic [13:0] ADDR_NO_OPERATION = 14'h0000;
    localparam logic [13:0] ADDR_ERROR_FLAGS = 14'h0001;
    localparam logic [13:0] ADDR_OTP_PROGRAM_CONTROL = 14'h0003;
    localparam logic [13:0] ADDR_CONFIG_PARITY_SUM = 14'h00D1;
    localparam logic [13:0] ADDR_CONFIG_PARITY_SUM_ALT = 14'h3FD0;
    localparam logic [13:0] ADDR_DIAGNOSTIC_STATUS = 14'h3FF5;
    localparam logic [13:0] ADDR_GAIN_CONTROL_VALUE = 14'h3FF9;
    localparam logic [13:0] ADDR_SINE_RAW = 14'h3FFA;
    localparam logic [13:0] ADDR_COSINE_RAW = 14'h3FFB;
    localparam logic [13:0] ADDR_ROTATIONAL_SPEED = 14'h3FFC;
    localparam logic [13:0] ADDR_FIELD_VECTOR_LENGTH = 14'h3FFD;
    localparam logic [13:0] ADDR_ANGLE_RAW = 14'h3FFE;
    localparam logic [13:0] ADDR_ANGLE_CORRECTED = 14'h3FFF;

    // error flag bit positions
    localparam int ERR_CORE_OVERFLOW = 10;
    localparam int ERR_OFFSET_CAL_PENDING = 9;
    localparam int ERR_BROKEN_SENSE_ELEMENT = 8;
    localparam int ERR_OSC_SUPERVISOR_FAULT = 7;
    localparam int ERR_SPI_CHECKSUM = 6;
    localparam int ERR_SPI_COMMAND = 5;
    localparam int ERR_SPI_FRAMING = 4;
    localparam int ERR_PARITY_DOUBLE_FAULT = 3;
    localparam int ERR_PARITY_SINGLE_FIX = 2;
    localparam int ERR_FIELD_BELOW_HALF = 1;
    localparam int ERR_GAIN_LIMIT = 0;

    // otp control bit positions
    localparam int CTL_OTP_VERIFY_REQUEST = 6;
    localparam int CTL_OTP_BURN_START = 3;
    localparam int CTL_SHADOW_RELOAD = 2;
    localparam int CTL_OTP_ACCESS_ENABLE = 0;

    // diagnostic bit positions
    localparam int DIAG_FRAME_COUNT_LSB = 11;
    localparam int DIAG_BROKEN_SENSE_ELEMENT = 10;
    localparam int DIAG_GAIN_SETTLED = 9;
    localparam int DIAG_OFFSET_CAL_DONE = 8;
    localparam int DIAG_SINE_OFFSET_DONE = 7;
    localparam int DIAG_COSINE_OFFSET_DONE = 6;
    localparam int DIAG_FIELD_BELOW_HALF = 5;
    localparam int DIAG_GAIN_HIGH = 4;
    localparam int DIAG_GAIN_LOW = 3;
    localparam int DIAG_CORE_OVERFLOW = 2;
    localparam int DIAG_CORE_LOOPS_DONE = 1;
    localparam int DIAG_SUPPLY_MODE = 0;

    localparam int ANGLE_SELECT_BIT = 6;
    localparam logic [7:0] GAIN_MIN = 8'h00;
    localparam logic [7:0] GAIN_MAX = 8'hFF;
    localparam int PARITY_SUM_WIDTH = 7;

    localparam logic [13:0] ERROR_FLAGS_RESET = 14'h0000;
    localparam logic [6:0] CTL_RESET = 7'h00;
    localparam logic [1:0] FRAME_COUNT_RESET = 2'h0;
    localparam logic [13:0] READ_DATA_RESET = 14'h0000;

    typedef struct packed {
        logic [13:0] addr;
        logic rd;
        logic wr;
        logic [13:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic core_overflow;
        logic offset_cal_pending;
        logic broken_sense_element;
        logic oscillator_supervisor_fault;
        logic field_below_half;
        logic gain_settled;
        logic sine_offset_done;
        logic cosine_offset_done;
        logic core_loops_done;
        logic supply_5v_mode;
        logic [7:0] gain_value;
        logic [13:0] sine_raw;
        logic [13:0] cosine_raw;
        logic [13:0] rotational_speed;
        logic [13:0] field_vector_length;
        logic [13:0] angle_raw;
        logic [13:0] angle_corrected;
    } core_status_s;

    typedef struct packed {
        logic spi_checksum_error;
        logic spi_command_error;
        logic spi_framing_error;
        logic spi_frame_done;
        logic parity_double_fault;
        logic parity_single_fix;
    } event_s;

    typedef struct packed {
        logic [7:0] output_disable;
        logic [7:0] zero_pos_msb;
        logic [7:0] zero_pos_lsb;
        logic [7:0] settings1;
        logic [7:0] settings2;
        logic [7:0] settings3;
    } config_s;

    typedef struct packed {
        logic otp_access_enable;
        logic otp_burn_start;
        logic shadow_reload;
        logic otp_verify_request;
    } otp_ctrl_s;

endpackage

// *** design/sensor_volatile_register_bank.sv ***
`timescale 1ns/1ps
module sensor_volatile_register_bank (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire sensor_regs_pkg::reg_req_s req_i,
    input wire sensor_regs_pkg::core_status_s core_i,
    input wire sensor_regs_pkg::event_s event_i,
    input wire sensor_regs_pkg::config_s config_i,
    output logic [13:0] rdata_o,
    output logic rvalid_o,
    output sensor_regs_pkg::otp_ctrl_s otp_o
);

    typedef struct packed {
        logic [13:0] error_flags;
        logic [6:0] ctl;
        logic [1:0] frame_count;
        logic [13:0] rdata;
        logic rvalid;
        logic burn_pulse;
        logic reload_pulse;
    } state_s;

    state_s st_reg;
    state_s st_next;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [6:0] parity_sum(input logic [47:0] bits);
        logic [6:0] s;
        s = 7'h00;
        for (int i = 0; i < 48; i++)
        begin
            s[i % sensor_regs_pkg::PARITY_SUM_WIDTH] ^= bits[i];
        end
        return s;
    endfunction

    function automatic logic [13:0] byte_word(input logic [7:0] b);
        return {6'h00, b};
    endfunction

    // ****************************************
    // event sources
    // ****************************************
    logic gain_low;
    logic gain_high;
    logic [13:0] err_set;
    logic [13:0] diag_word;
    logic [13:0] read_word;
    logic [6:0] cfg_sum;
    logic err_read;
    logic ctl_write;

    assign gain_low = core_i.gain_value == sensor_regs_pkg::GAIN_MIN;
    assign gain_high = core_i.gain_value == sensor_regs_pkg::GAIN_MAX;
    assign cfg_sum = parity_sum(config_i);
    assign err_read = req_i.rd
        && req_i.addr == sensor_regs_pkg::ADDR_ERROR_FLAGS;
    assign ctl_write = req_i.wr
        && req_i.addr == sensor_regs_pkg::ADDR_OTP_PROGRAM_CONTROL;

    always_comb
    begin
        err_set = 14'h0000;
        err_set[sensor_regs_pkg::ERR_CORE_OVERFLOW] =
            core_i.core_overflow;
        err_set[sensor_regs_pkg::ERR_OFFSET_CAL_PENDING] =
            core_i.offset_cal_pending;
        err_set[sensor_regs_pkg::ERR_BROKEN_SENSE_ELEMENT] =
            core_i.broken_sense_element;
        err_set[sensor_regs_pkg::ERR_OSC_SUPERVISOR_FAULT] =
            core_i.oscillator_supervisor_fault;
        err_set[sensor_regs_pkg::ERR_SPI_CHECKSUM] =
            event_i.spi_checksum_error;
        err_set[sensor_regs_pkg::ERR_SPI_COMMAND] =
            event_i.spi_command_error;
        err_set[sensor_regs_pkg::ERR_SPI_FRAMING] =
            event_i.spi_framing_error;
        err_set[sensor_regs_pkg::ERR_PARITY_DOUBLE_FAULT] =
            event_i.parity_double_fault;
        err_set[sensor_regs_pkg::ERR_PARITY_SINGLE_FIX] =
            event_i.parity_single_fix;
        err_set[sensor_regs_pkg::ERR_FIELD_BELOW_HALF] =
            gain_high && core_i.field_below_half;
        err_set[sensor_regs_pkg::ERR_GAIN_LIMIT] =
            gain_low || gain_high;
    end

    // ****************************************
    // diagnostic word
    // ****************************************
    always_comb
    begin
        diag_word = 14'h0000;
        diag_word[sensor_regs_pkg::DIAG_FRAME_COUNT_LSB +: 2] =
            st_reg.frame_count;
        diag_word[sensor_regs_pkg::DIAG_BROKEN_SENSE_ELEMENT] =
            core_i.broken_sense_element;
        diag_word[sensor_regs_pkg::DIAG_GAIN_SETTLED] =
            core_i.gain_settled;
        diag_word[sensor_regs_pkg::DIAG_OFFSET_CAL_DONE] =
            !core_i.offset_cal_pending;
        diag_word[sensor_regs_pkg::DIAG_SINE_OFFSET_DONE] =
            core_i.sine_offset_done;
        diag_word[sensor_regs_pkg::DIAG_COSINE_OFFSET_DONE] =
            core_i.cosine_offset_done;
        diag_word[sensor_regs_pkg::DIAG_FIELD_BELOW_HALF] =
            core_i.field_below_half;
        diag_word[sensor_regs_pkg::DIAG_GAIN_HIGH] = gain_high;
        diag_word[sensor_regs_pkg::DIAG_GAIN_LOW] = gain_low;
        diag_word[sensor_regs_pkg::DIAG_CORE_OVERFLOW] =
            core_i.core_overflow;
        diag_word[sensor_regs_pkg::DIAG_CORE_LOOPS_DONE] =
            core_i.core_loops_done;
        diag_word[sensor_regs_pkg::DIAG_SUPPLY_MODE] =
            core_i.supply_5v_mode;
    end

    // ****************************************
    // read decode
    // ****************************************
    always_comb
    begin
        case (req_i.addr)
            sensor_regs_pkg::ADDR_ERROR_FLAGS:
                read_word = st_reg.error_flags;
            sensor_regs_pkg::ADDR_OTP_PROGRAM_CONTROL:
                read_word = {7'h00, st_reg.ctl};
            sensor_regs_pkg::ADDR_CONFIG_PARITY_SUM,
            sensor_regs_pkg::ADDR_CONFIG_PARITY_SUM_ALT:
                read_word = {7'h00, cfg_sum};
            sensor_regs_pkg::ADDR_DIAGNOSTIC_STATUS:
                read_word = diag_word;
            sensor_regs_pkg::ADDR_GAIN_CONTROL_VALUE:
                read_word = byte_word(core_i.gain_value);
            sensor_regs_pkg::ADDR_SINE_RAW:
                read_word = core_i.sine_raw;
            sensor_regs_pkg::ADDR_COSINE_RAW:
                read_word = core_i.cosine_raw;
            sensor_regs_pkg::ADDR_ROTATIONAL_SPEED:
                read_word = core_i.rotational_speed;
            sensor_regs_pkg::ADDR_FIELD_VECTOR_LENGTH:
                read_word = core_i.field_vector_length;
            sensor_regs_pkg::ADDR_ANGLE_RAW:
                read_word = core_i.angle_raw;
            sensor_regs_pkg::ADDR_ANGLE_CORRECTED:
                read_word =
                    config_i.settings2[sensor_regs_pkg::ANGLE_SELECT_BIT]
                    ? core_i.angle_raw
                    : core_i.angle_corrected;
            default:
                read_word = 14'h0000;
        endcase
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        st_next = st_reg;
        // set wins over the read clear
        st_next.error_flags = (err_read ? 14'h0000 : st_reg.error_flags)
            | err_set;
        st_next.rvalid = req_i.rd;
        st_next.rdata = req_i.rd ? read_word : st_reg.rdata;
        st_next.burn_pulse = 1'b0;
        st_next.reload_pulse = 1'b0;
        if (event_i.spi_frame_done)
        begin
            st_next.frame_count = st_reg.frame_count + 2'h1;
        end
        // only the control register takes writes
        if (ctl_write)
        begin
            st_next.ctl = 7'h00;
            st_next.ctl[sensor_regs_pkg::CTL_OTP_ACCESS_ENABLE] =
                req_i.wdata[sensor_regs_pkg::CTL_OTP_ACCESS_ENABLE];
            st_next.ctl[sensor_regs_pkg::CTL_SHADOW_RELOAD] =
                req_i.wdata[sensor_regs_pkg::CTL_SHADOW_RELOAD];
            st_next.ctl[sensor_regs_pkg::CTL_OTP_BURN_START] =
                req_i.wdata[sensor_regs_pkg::CTL_OTP_BURN_START];
            st_next.ctl[sensor_regs_pkg::CTL_OTP_VERIFY_REQUEST] =
                req_i.wdata[sensor_regs_pkg::CTL_OTP_VERIFY_REQUEST];
            st_next.burn_pulse =
                req_i.wdata[sensor_regs_pkg::CTL_OTP_BURN_START];
            st_next.reload_pulse =
                req_i.wdata[sensor_regs_pkg::CTL_SHADOW_RELOAD];
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            st_reg.error_flags <= sensor_regs_pkg::ERROR_FLAGS_RESET;
            st_reg.ctl <= sensor_regs_pkg::CTL_RESET;
            st_reg.frame_count <= sensor_regs_pkg::FRAME_COUNT_RESET;
            st_reg.rdata <= sensor_regs_pkg::READ_DATA_RESET;
            st_reg.rvalid <= 1'b0;
            st_reg.burn_pulse <= 1'b0;
            st_reg.reload_pulse <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign rdata_o = st_reg.rdata;
    assign rvalid_o = st_reg.rvalid;
    assign otp_o.otp_access_enable =
        st_reg.ctl[sensor_regs_pkg::CTL_OTP_ACCESS_ENABLE];
    assign otp_o.otp_verify_request =
        st_reg.ctl[sensor_regs_pkg::CTL_OTP_VERIFY_REQUEST];
    assign otp_o.otp_burn_start = st_reg.burn_pulse;
    assign otp_o.shadow_reload = st_reg.reload_pulse;

    // ****************************************
    // checks
    // ****************************************
    a_err_read_clear:
    assert property (@(posedge mclk_i) disable iff (rst_i)
        err_read && err_set == 14'h0000 |=> st_reg.error_flags == 14'h0000
            && rdata_o == $past(st_reg.error_flags))
    else $error("error flags not returned and cleared");

    a_err_overflow_set:
    assert property (@(posedge mclk_i) disable iff (rst_i)
        core_i.core_overflow |=> st_reg.error_flags[10])
    else $error("overflow flag not set");

    a_err_sticky_hold:
    assert property (@(posedge mclk_i) disable iff (rst_i)
        event_i.spi_checksum_error ##1 !err_read |=> st_reg.error_flags[6])
    else $error("checksum flag lost");

    a_gain_limit_flag:
    assert property (@(posedge mclk_i) disable iff (rst_i)
        core_i.gain_value == 8'h00 |=> st_reg.error_flags[0])
    else $error("gain limit flag not set");

    a_field_half_flag:
    assert property (@(posedge mclk_i) disable iff (rst_i)
        (core_i.gain_value == 8'hFF && core_i.field_below_half)
        |=> st_reg.error_flags[1] && st_reg.error_flags[0])
    else $error("field half flag not set");

    a_burn_pulse_once:
    assert property (@(posedge mclk_i) disable iff (rst_i)
        ctl_write && req_i.wdata[3] |=> otp_o.otp_burn_start
            ##1 !otp_o.otp_burn_start || $past(ctl_write))
    else $error("burn start pulse wrong");

    a_reload_pulse:
    assert property (@(posedge mclk_i) disable iff (rst_i)
        otp_o.shadow_reload |-> $past(ctl_write) && $past(req_i.wdata[2]))
    else $error("reload without write");

    a_access_enable:
    assert property (@(posedge mclk_i) disable iff (rst_i)
        ctl_write |=> otp_o.otp_access_enable == $past(req_i.wdata[0]))
    else $error("access enable not taken");

    a_angle_select:
    assert property (@(posedge mclk_i) disable iff (rst_i)
        req_i.rd && req_i.addr == 14'h3FFF && !config_i.settings2[6]
        |=> rvalid_o && rdata_o == $past(core_i.angle_corrected))
    else $error("top address angle wrong");

    a_unmapped_zero:
    assert property (@(posedge mclk_i) disable iff (rst_i)
        req_i.rd && req_i.addr == 14'h0002 |=> rvalid_o && rdata_o == 14'h0000)
    else $error("unmapped read not zero");

    a_frame_count:
    assert property (@(posedge mclk_i) disable iff (rst_i)
        event_i.spi_frame_done
        |=> st_reg.frame_count == $past(st_reg.frame_count) + 2'h1)
    else $error("frame counter not advanced");

endmodule

// *** sim/sensor_host_master.sv ***
`timescale 1ns/1ps
// ****************************************
// host side of the register port
// ****************************************
module sensor_host_master (
    input wire logic mclk_i,
    input wire logic [13:0] rdata_i,
    input wire logic rvalid_i,
    output sensor_regs_pkg::reg_req_s req_o
);
    initial
    begin
        req_o = '0;
    end

    task automatic write_reg(input logic [13:0] a, input logic [13:0] d);
        @(posedge mclk_i);
        req_o.addr <= a;
        req_o.wdata <= d;
        req_o.wr <= 1'b1;
        @(posedge mclk_i);
        req_o.wr <= 1'b0;
        // released lines never keep the last value
        req_o.addr <= ~a;
        req_o.wdata <= ~d;
    endtask

    // answer is due exactly one cycle after the read edge
    task automatic read_reg(input logic [13:0] a, output logic [13:0] d,
                            output bit ok);
        @(posedge mclk_i);
        req_o.addr <= a;
        req_o.rd <= 1'b1;
        @(posedge mclk_i);
        req_o.rd <= 1'b0;
        req_o.addr <= ~a;
        // look once the answer has settled
        #1;
        ok = (rvalid_i === 1'b1);
        d = rdata_i;
    endtask

    task automatic read_flags_then_diag(output logic [13:0] f,
                                        output logic [13:0] dg,
                                        output bit ok);
        bit ok2;
        ok2 = 1'b1;
        dg = '0;
        read_reg(sensor_regs_pkg::ADDR_ERROR_FLAGS, f, ok);
        if (f !== 14'h0000)
            read_reg(sensor_regs_pkg::ADDR_DIAGNOSTIC_STATUS, dg, ok2);
        ok = ok & ok2;
    endtask
endmodule

// *** sim/sensor_volatile_register_bank_tb.sv ***
`timescale 1ns/1ps
module sensor_volatile_register_bank_tb;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    sensor_regs_pkg::reg_req_s req;
    sensor_regs_pkg::core_status_s core = '0;
    sensor_regs_pkg::core_status_s base = '0;
    sensor_regs_pkg::core_status_s c;
    sensor_regs_pkg::event_s ev = '0;
    sensor_regs_pkg::config_s cfg = '0;
    sensor_regs_pkg::otp_ctrl_s otp;
    logic [13:0] rdata;
    logic rvalid;
    logic [13:0] got;
    logic [13:0] diag;
    logic [6:0] par;
    logic [5:0] evv [5] = '{6'h20, 6'h10, 6'h08, 6'h02, 6'h01};
    bit ok;
    int mismatches = 0;
    int cmp_count = 0;

    always #12.5 mclk_i = ~mclk_i;

    sensor_volatile_register_bank u_sensor_volatile_register_bank (
        .mclk_i(mclk_i), .rst_i(rst_i), .req_i(req), .core_i(core),
        .event_i(ev), .config_i(cfg), .rdata_o(rdata), .rvalid_o(rvalid),
        .otp_o(otp));

    sensor_host_master u_sensor_host_master (
        .mclk_i(mclk_i), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));

    task automatic report_and_stop();
        $display("mismatches %0d compares %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [13:0] g, input logic [13:0] e,
                         input string what);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] %0t %s got %h want %h", $time, what, g, e);
        end
    endtask

    task automatic need(input bit k);
        if (!k)
        begin
            mismatches++;
            $display("[FAIL] %0t read answer missing", $time);
            report_and_stop();
        end
    endtask

    task automatic rd(input logic [13:0] a, input logic [13:0] e,
                      input string what);
        u_sensor_host_master.read_reg(a, got, ok);
        need(ok);
        check(got, e, what);
    endtask

    // one cycle of cause, then read and clear the flags
    task automatic err_case(input sensor_regs_pkg::core_status_s cs,
                            input logic [5:0] e, input logic [13:0] x);
        @(posedge mclk_i);
        core <= cs;
        ev <= sensor_regs_pkg::event_s'(e);
        @(posedge mclk_i);
        core <= base;
        ev <= '0;
        u_sensor_host_master.read_flags_then_diag(got, diag, ok);
        need(ok);
        check(got, x, "flags");
        rd(sensor_regs_pkg::ADDR_ERROR_FLAGS, 14'h0000, "flags clear");
    endtask

    task automatic otp_is(input logic [3:0] x);
        #1;
        check(14'(otp), 14'(x), "otp outputs");
    endtask

    initial
    begin
        #2_000_000;
        mismatches++;
        $display("[FAIL] %0t run limit reached", $time);
        report_and_stop();
    end

    initial
    begin
        base.gain_value = 8'h80;
        core = base;
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        #1;
        check(rdata, 14'h0000, "rdata reset");
        check(14'(rvalid), 14'h0000, "rvalid reset");
        check(14'(otp), 14'h0000, "otp reset");
        rd(sensor_regs_pkg::ADDR_ERROR_FLAGS, 14'h0000, "err rst");
        rd(sensor_regs_pkg::ADDR_OTP_PROGRAM_CONTROL, 14'h0000, "ctl");
        rd(sensor_regs_pkg::ADDR_NO_OPERATION, 14'h0000, "idle");
        // ****************************************
        // data registers and address decode
        // ****************************************
        base.sine_raw = 14'h1234;
        base.cosine_raw = 14'h2345;
        base.rotational_speed = 14'h3FF6;
        base.field_vector_length = 14'h0ABC;
        base.angle_raw = 14'h1357;
        base.angle_corrected = 14'h2468;
        base.gain_value = 8'hA5;
        @(posedge mclk_i);
        core <= base;
        rd(sensor_regs_pkg::ADDR_SINE_RAW, 14'h1234, "sine");
        rd(sensor_regs_pkg::ADDR_COSINE_RAW, 14'h2345, "cosine");
        rd(sensor_regs_pkg::ADDR_ROTATIONAL_SPEED, 14'h3FF6, "speed");
        rd(sensor_regs_pkg::ADDR_FIELD_VECTOR_LENGTH, 14'h0ABC,
            "length");
        rd(sensor_regs_pkg::ADDR_ANGLE_RAW, 14'h1357, "raw angle");
        rd(sensor_regs_pkg::ADDR_ANGLE_CORRECTED, 14'h2468, "angle");
        rd(sensor_regs_pkg::ADDR_GAIN_CONTROL_VALUE, 14'h00A5, "gain");
        rd(14'h0002, 14'h0000, "unmapped");
        rd(14'h1FFF, 14'h0000, "partial decode");
        rd(14'h3FF8, 14'h0000, "near decode");
        @(posedge mclk_i);
        cfg.settings2[6] <= 1'b1;
        rd(sensor_regs_pkg::ADDR_ANGLE_CORRECTED, 14'h1357, "select");
        u_sensor_host_master.write_reg(sensor_regs_pkg::ADDR_SINE_RAW,
            14'h0000);
        rd(sensor_regs_pkg::ADDR_SINE_RAW, 14'h1234, "ro write");
        // ****************************************
        // sticky error flags
        // ****************************************
        for (int i = 0; i < 5; i++)
            err_case(base, evv[i], 14'h0040 >> i);
        for (int i = 0; i < 4; i++)
        begin
            c = base;
            c.core_overflow = (i == 0);
            c.offset_cal_pending = (i == 1);
            c.broken_sense_element = (i == 2);
            c.oscillator_supervisor_fault = (i == 3);
            err_case(c, 6'h00, 14'h0400 >> i);
        end
        c = base;
        c.gain_value = 8'h00;
        err_case(c, 6'h00, 14'h0001);
        c.gain_value = 8'hFF;
        err_case(c, 6'h00, 14'h0001);
        c.field_below_half = 1'b1;
        err_case(c, 6'h00, 14'h0003);
        c.gain_value = 8'h80;
        err_case(c, 6'h00, 14'h0000);
        // ****************************************
        // diagnostic register, live fields
        // ****************************************
        for (int i = 0; i < 5; i++)
        begin
            @(posedge mclk_i);
            ev.spi_frame_done <= 1'b1;
            @(posedge mclk_i);
            ev.spi_frame_done <= 1'b0;
        end
        c = base;
        {c.gain_value, c.broken_sense_element, c.gain_settled} = 10'h3FF;
        {c.sine_offset_done, c.field_below_half, c.core_overflow} = 3'h7;
        {c.core_loops_done, c.supply_5v_mode} = 2'h3;
        @(posedge mclk_i);
        core <= c;
        rd(sensor_regs_pkg::ADDR_DIAGNOSTIC_STATUS, 14'h0FB7,
            "diag");
        c = base;
        {c.gain_value, c.offset_cal_pending, c.cosine_offset_done} = 10'h003;
        @(posedge mclk_i);
        core <= c;
        rd(sensor_regs_pkg::ADDR_DIAGNOSTIC_STATUS, 14'h0848,
            "diag");
        @(posedge mclk_i);
        core <= base;
        // both diagnostic cases pile up in the sticky flags
        rd(sensor_regs_pkg::ADDR_ERROR_FLAGS, 14'h0703,
            "flags");
        // ****************************************
        // otp control register
        // ****************************************
        u_sensor_host_master.write_reg(14'h0003, 14'h004D);
        otp_is(4'hF);
        @(posedge mclk_i);
        otp_is(4'h9);
        rd(sensor_regs_pkg::ADDR_OTP_PROGRAM_CONTROL, 14'h004D, "ctl");
        u_sensor_host_master.write_reg(14'h0003, 14'h0004);
        otp_is(4'h2);
        u_sensor_host_master.write_reg(14'h0003, 14'h3FFF);
        otp_is(4'hF);
        rd(sensor_regs_pkg::ADDR_OTP_PROGRAM_CONTROL, 14'h004D, "ctl");
        // ****************************************
        // parity sum over configuration
        // ****************************************
        @(posedge mclk_i);
        cfg <= 48'h0123_4567_89AB;
        par = '0;
        for (int i = 0; i < 48; i++)
            par[i % 7] ^= 1'(48'h0123_4567_89AB >> i);
        rd(sensor_regs_pkg::ADDR_CONFIG_PARITY_SUM, 14'(par), "sum");
        rd(sensor_regs_pkg::ADDR_CONFIG_PARITY_SUM_ALT, 14'(par), "sum");
        // ****************************************
        // reset in mid-run
        // ****************************************
        @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        otp_is(4'h0);
        rd(sensor_regs_pkg::ADDR_OTP_PROGRAM_CONTROL, 14'h0000, "ctl");
        report_and_stop();
    end
endmodule
